// file: hdl/ddr_mode_pkg.sv
package ddr_mode_pkg;

  // ----------------------------------------
  // link commands and controller operations
  // ----------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP  = 4'h0,
    CMD_MRS  = 4'h1,
    CMD_REF  = 4'h2,
    CMD_SRE  = 4'h3,
    CMD_SRX  = 4'h4,
    CMD_ZQCL = 4'h5,
    CMD_ZQCS = 4'h6,
    CMD_ACT  = 4'h7,
    CMD_PRE  = 4'h8,
    CMD_PREA = 4'h9,
    CMD_WR   = 4'hA,
    CMD_RD   = 4'hB,
    CMD_PDE  = 4'hC
  } cmd_t;

  typedef enum logic [1:0] {
    OP_DLL_OFF = 2'h0,
    OP_DLL_ON  = 2'h1,
    OP_VREF    = 2'h2,
    OP_ABORT   = 2'h3
  } op_t;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CK_MHZ = 250;
  localparam int T_MOD_NS = 60;
  localparam int T_MRD_NS = 32;
  localparam int T_CKSRE_NS = 40;
  localparam int T_CKSRX_NS = 40;
  localparam int T_XS_FAST_NS = 120;
  localparam int T_XS_ABORT_NS = 160;
  localparam int T_XS_NS = 360;
  localparam int T_RFC_NS = 260;
  localparam int SR_REF_NS = 7800;
  localparam int T_MOD_CYC = (T_MOD_NS * CK_MHZ + 999) / 1000;
  localparam int T_MRD_CYC = (T_MRD_NS * CK_MHZ + 999) / 1000;
  localparam int T_CKSRE_CYC = (T_CKSRE_NS * CK_MHZ + 999) / 1000;
  localparam int T_CKSRX_CYC = (T_CKSRX_NS * CK_MHZ + 999) / 1000;
  localparam int T_XS_FAST_CYC = (T_XS_FAST_NS * CK_MHZ + 999) / 1000;
  localparam int T_XS_ABORT_CYC = (T_XS_ABORT_NS * CK_MHZ + 999) / 1000;
  localparam int T_XS_CYC = (T_XS_NS * CK_MHZ + 999) / 1000;
  localparam int T_RFC_CYC = (T_RFC_NS * CK_MHZ + 999) / 1000;
  localparam int SR_REF_CYC = (SR_REF_NS * CK_MHZ) / 1000;
  localparam int T_ZQOPER_CK = 512;
  localparam int DLLK_LOW_CK = 597;
  localparam int DLLK_MID_CK = 768;
  localparam int DLLK_HIGH_CK = 1024;
  localparam int WAIT_W = 12;

  // ----------------------------------------
  // mode register fields
  // ----------------------------------------
  localparam logic [2:0] MR0 = 3'h0;
  localparam logic [2:0] MR1 = 3'h1;
  localparam logic [2:0] MR2 = 3'h2;
  localparam logic [2:0] MR3 = 3'h3;
  localparam logic [2:0] MR4 = 3'h4;
  localparam logic [2:0] MR_VREF = 3'h6;
  localparam int MR0_DLL_RST = 8;
  localparam int MR1_DLL_EN = 0;
  localparam int MR4_SR_ABORT = 9;
  localparam int VREF_CODE_LSB = 0;
  localparam int VREF_RANGE_BIT = 6;
  localparam int VREF_TRAIN_BIT = 7;
  localparam int CCD_FIELD_LSB = 10;
  localparam int VREF_W = 6;
  localparam int CCD_W = 3;
  localparam logic [5:0] VREF_MAX_CODE = 6'h32;
  // levels in hundredths of a percent of the io supply
  localparam logic [13:0] VREF_R1_BASE = 14'h1770;
  localparam logic [13:0] VREF_R2_BASE = 14'h1194;
  localparam logic [13:0] VREF_STEP = 14'h0041;
  localparam logic [2:0] CCD_MAX_CODE = 3'h4;
  localparam logic [3:0] CCD_MIN_CK = 4'h4;

  function automatic logic [WAIT_W-1:0] dllk_f(input logic [2:0] ccd);
    if (ccd <= 3'h1) begin
      return WAIT_W'(DLLK_LOW_CK);
    end
    if (ccd == 3'h2) begin
      return WAIT_W'(DLLK_MID_CK);
    end
    return WAIT_W'(DLLK_HIGH_CK);
  endfunction

  // ----------------------------------------
  // controller registers
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int ST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam int CFG_RANGE = 6;
  localparam int CFG_CCD_LSB = 7;
  localparam int CFG_ABORT = 10;
  localparam int CFG_ODT = 11;
  localparam int CFG_W = 12;
  localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;

endpackage

// file: hdl/mode_link_if.sv
interface mode_link_if;
  logic cke;
  logic odt;
  ddr_mode_pkg::cmd_t cmd;
  logic [2:0] mr_sel;
  logic [13:0] addr;

  modport ctrl (output cke, output odt, output cmd, output mr_sel,
                output addr);
  modport dram (input cke, input odt, input cmd, input mr_sel,
                input addr);
endinterface

// file: hdl/dram_mode_end.sv
module dram_mode_end
  import ddr_mode_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  mode_link_if.dram link,
  output logic dll_en_q,
  output logic dll_locked_q,
  output logic [13:0] vref_level_q,
  output logic vref_range_q,
  output logic vref_train_q,
  output logic vref_bad_q,
  output logic [3:0] ccd_l_q,
  output logic ccd_bad_q,
  output logic self_ref_q,
  output logic [15:0] ref_count_q,
  output logic early_cmd_q
);

  logic mrs;
  logic [13:0] a;
  logic [VREF_W-1:0] vcode;
  logic [CCD_W-1:0] ccode;
  logic abort_q;
  logic [WAIT_W-1:0] dllk_need_q;
  logic [WAIT_W-1:0] lock_cnt_q;
  logic [WAIT_W-1:0] sr_tmr_q;
  logic [WAIT_W-1:0] rfc_q;
  logic [WAIT_W-1:0] since_q;
  logic [WAIT_W-1:0] xs_need_q;
  logic ref_start;
  logic ref_cancel;
  logic fast_ok;
  logic full_ok;

  assign mrs = link.cmd == CMD_MRS;
  assign a = link.addr;
  assign vcode = a[VREF_CODE_LSB +: VREF_W];
  assign ccode = a[CCD_FIELD_LSB +: CCD_W];

  // ----------------------------------------
  // mode fields
  // ----------------------------------------
  // ignored mode slot never decoded
  always_ff @(posedge mclk) begin
    if (reset) begin
      vref_train_q <= 1'b0;
      vref_range_q <= 1'b0;
      vref_level_q <= VREF_R1_BASE;
      vref_bad_q <= 1'b0;
      ccd_l_q <= CCD_MIN_CK;
      ccd_bad_q <= 1'b0;
      dllk_need_q <= dllk_f(3'h0);
      abort_q <= 1'b0;
    end else if (mrs && link.mr_sel == MR_VREF) begin
      vref_train_q <= a[VREF_TRAIN_BIT];
      vref_bad_q <= vcode > VREF_MAX_CODE;
      if (vcode <= VREF_MAX_CODE) begin
        vref_range_q <= a[VREF_RANGE_BIT];
        vref_level_q <= (a[VREF_RANGE_BIT] ? VREF_R2_BASE : VREF_R1_BASE)
                        + 14'(vcode) * VREF_STEP;
      end
      ccd_bad_q <= ccode > CCD_MAX_CODE;
      if (ccode <= CCD_MAX_CODE) begin
        ccd_l_q <= CCD_MIN_CK + {1'b0, ccode};
        dllk_need_q <= dllk_f(ccode);
      end
    end else if (mrs && link.mr_sel == MR4) begin
      abort_q <= a[MR4_SR_ABORT];
    end
  end

  // ----------------------------------------
  // dll
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      dll_en_q <= 1'b1;
      dll_locked_q <= 1'b0;
      lock_cnt_q <= '0;
    end else if (mrs && link.mr_sel == MR1) begin
      dll_en_q <= a[MR1_DLL_EN];
      if (!a[MR1_DLL_EN]) begin
        dll_locked_q <= 1'b0;
        lock_cnt_q <= '0;
      end
    end else if (mrs && link.mr_sel == MR0 && a[MR0_DLL_RST] && dll_en_q)
    begin
      lock_cnt_q <= dllk_need_q;
      dll_locked_q <= 1'b0;
    end else if (lock_cnt_q != '0) begin
      lock_cnt_q <= lock_cnt_q - 1'b1;
      dll_locked_q <= lock_cnt_q == 12'h001;
    end
  end

  // ----------------------------------------
  // refresh and self refresh
  // ----------------------------------------
  assign ref_start = rfc_q == '0 &&
    ((link.cmd == CMD_REF && !self_ref_q) ||
     (self_ref_q && sr_tmr_q == WAIT_W'(SR_REF_CYC - 1)));
  assign ref_cancel = link.cmd == CMD_SRX && self_ref_q && abort_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      self_ref_q <= 1'b0;
      sr_tmr_q <= '0;
    end else if (link.cmd == CMD_SRE && !self_ref_q) begin
      self_ref_q <= 1'b1;
      sr_tmr_q <= '0;
    end else if (link.cmd == CMD_SRX) begin
      self_ref_q <= 1'b0;
    end else if (self_ref_q) begin
      sr_tmr_q <= ref_start ? '0 : sr_tmr_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rfc_q <= '0;
    end else if (ref_cancel) begin
      rfc_q <= '0;
    end else if (ref_start) begin
      rfc_q <= WAIT_W'(T_RFC_CYC);
    end else if (rfc_q != '0) begin
      rfc_q <= rfc_q - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ref_count_q <= '0;
    end else if (!ref_cancel && rfc_q == 12'h001) begin
      ref_count_q <= ref_count_q + 1'b1;
    end
  end

  // ----------------------------------------
  // exit window checks
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      since_q <= WAIT_W'(T_XS_CYC);
      xs_need_q <= WAIT_W'(T_XS_CYC);
    end else if (link.cmd == CMD_SRX && self_ref_q) begin
      since_q <= '0;
      xs_need_q <= WAIT_W'(abort_q ? T_XS_ABORT_CYC : T_XS_CYC);
    end else if (since_q < WAIT_W'(T_XS_CYC)) begin
      since_q <= since_q + 1'b1;
    end
  end

  assign fast_ok = since_q >= WAIT_W'(T_XS_FAST_CYC);
  assign full_ok = since_q >= xs_need_q;

  // sticky until reset; flags what the controller got wrong
  always_ff @(posedge mclk) begin
    if (reset) begin
      early_cmd_q <= 1'b0;
    end else if (!full_ok && link.cmd != CMD_NOP) begin
      // only zq and latency writes early
      if (link.cmd == CMD_ZQCL || link.cmd == CMD_ZQCS) begin
        early_cmd_q <= early_cmd_q | !fast_ok;
      end else if (mrs) begin
        early_cmd_q <= early_cmd_q | !fast_ok |
          !(link.mr_sel == MR0 || link.mr_sel == MR2 ||
            link.mr_sel == MR3);
      end else begin
        early_cmd_q <= 1'b1;
      end
    end
  end

endmodule

// file: hdl/mode_seq_ctrl.sv
// Behaviour
// - vref code selects fifty 0.65% steps
// - range bit picks 60-92% or 45-77%
// - training enabled on every vref write
// - ccd field programmed for the frequency
// - ccd codes 0-4 mean 4-8 clocks
// - reserved mode bits always written zero
// - device ignores the unused mode slot
// - enable bit low turns dll off
// - dll-off write idle, termination off
// - off order mod, enter, cksre, cksrx
// - cke high after exit until mod
// - odt low after exit until mod
// - only zq and latency writes early
// - abort drops refresh, shorter exit wait
// - extra refresh before next self refresh
// - full exit wait before other commands
// - wait mod after last mode write
// - cke high, odt low until dllk
// - exit wait, enable dll, mrd, reset
// - latency writes then zq after mod
// - wait dllk and zqoper before use
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
module mode_seq_ctrl
  import ddr_mode_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  mode_link_if.ctrl link
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT  = 3'b100
  } state_t;

  typedef struct packed {
    cmd_t cmd;
    logic [2:0] mr;
    logic [13:0] addr;
    logic [WAIT_W-1:0] wait_c;
    logic cke;
    logic last;
  } step_t;

  localparam int ZQ_XS_CYC =
    T_ZQOPER_CK > T_XS_CYC ? T_ZQOPER_CK : T_XS_CYC;

  state_t state_q;
  op_t op_q;
  logic [2:0] idx_q;
  logic [WAIT_W-1:0] wait_q;
  logic [CFG_W-1:0] cfg_q;
  logic done_q;
  logic refused_q;
  logic ap_q;
  logic apw_q;
  logic [7:0] apa_q;
  logic wr_ctrl;
  logic wr_status;
  logic wr_cfg;
  logic go;
  logic seq_end;
  step_t st;

  // ----------------------------------------
  // sequence table
  // ----------------------------------------
  function automatic step_t step_f(input op_t op, input logic [2:0] idx,
                                   input logic [CFG_W-1:0] cfg);
    step_t s;
    logic [13:0] vref_word;
    logic [WAIT_W-1:0] dllk;
    s = '{cmd: CMD_NOP, mr: 3'h0, addr: 14'h0000,
          wait_c: WAIT_W'(T_MOD_CYC), cke: 1'b1, last: 1'b0};
    vref_word = 14'h0000;
    vref_word[VREF_CODE_LSB +: VREF_W] = cfg[VREF_W-1:0];
    vref_word[VREF_RANGE_BIT] = cfg[CFG_RANGE];
    vref_word[VREF_TRAIN_BIT] = 1'b1;
    vref_word[CCD_FIELD_LSB +: CCD_W] = cfg[CFG_CCD_LSB +: CCD_W];
    dllk = dllk_f(cfg[CFG_CCD_LSB +: CCD_W]);
    case (op)
      OP_DLL_OFF: begin
        case (idx)
          3'h0: begin
            s.cmd = CMD_MRS;
            s.mr = MR1;
          end
          3'h1: begin
            s.cmd = CMD_SRE;
            s.cke = 1'b0;
            s.wait_c = WAIT_W'(T_CKSRE_CYC);
          end
          // clock may change here
          3'h2: begin
            s.cke = 1'b0;
            s.wait_c = WAIT_W'(T_CKSRX_CYC);
          end
          3'h3: begin
            s.cmd = CMD_SRX;
            s.wait_c = WAIT_W'(T_XS_FAST_CYC);
          end
          3'h4: begin
            s.cmd = CMD_ZQCL;
            s.wait_c = WAIT_W'(ZQ_XS_CYC);
          end
          3'h5: begin
            s.cmd = CMD_MRS;
            s.mr = MR_VREF;
            s.addr = vref_word;
          end
          default: begin
            s.cmd = CMD_REF;
            s.wait_c = WAIT_W'(T_RFC_CYC);
            s.last = 1'b1;
          end
        endcase
      end
      OP_DLL_ON: begin
        case (idx)
          3'h0: begin
            s.cmd = CMD_SRE;
            s.cke = 1'b0;
            s.wait_c = WAIT_W'(T_CKSRE_CYC);
          end
          3'h1: begin
            s.cke = 1'b0;
            s.wait_c = WAIT_W'(T_CKSRX_CYC);
          end
          3'h2: begin
            s.cmd = CMD_SRX;
            s.wait_c = WAIT_W'(cfg[CFG_ABORT] ? T_XS_ABORT_CYC : T_XS_CYC);
          end
          3'h3: begin
            s.cmd = CMD_MRS;
            s.mr = MR1;
            s.addr[MR1_DLL_EN] = 1'b1;
            s.wait_c = WAIT_W'(T_MRD_CYC);
          end
          3'h4: begin
            s.cmd = CMD_MRS;
            s.mr = MR0;
            s.addr[MR0_DLL_RST] = 1'b1;
            s.wait_c = WAIT_W'(T_MRD_CYC);
          end
          3'h5: begin
            s.cmd = CMD_MRS;
            s.mr = MR_VREF;
            s.addr = vref_word;
          end
          3'h6: begin
            s.cmd = CMD_ZQCL;
            s.wait_c = dllk > WAIT_W'(T_ZQOPER_CK) ?
                       dllk : WAIT_W'(T_ZQOPER_CK);
          end
          default: begin
            s.cmd = CMD_REF;
            s.wait_c = WAIT_W'(T_RFC_CYC);
            s.last = 1'b1;
          end
        endcase
      end
      OP_VREF: begin
        s.cmd = CMD_MRS;
        s.mr = MR_VREF;
        s.addr = vref_word;
        s.last = 1'b1;
      end
      default: begin
        s.cmd = CMD_MRS;
        s.mr = MR4;
        s.addr[MR4_SR_ABORT] = cfg[CFG_ABORT];
        s.last = 1'b1;
      end
    endcase
    return s;
  endfunction

  assign st = step_f(op_q, idx_q, cfg_q);
  assign go = wr_ctrl && hwdata[CTRL_GO];
  assign seq_end = state_q == ST_WAIT && wait_q == '0 && st.last;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // every step waits its time
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      op_q <= OP_VREF;
      idx_q <= 3'h0;
      wait_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            op_q <= op_t'(hwdata[CTRL_OP_LSB +: 2]);
            idx_q <= 3'h0;
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          wait_q <= st.wait_c;
          state_q <= ST_WAIT;
        end
        default: begin
          if (wait_q != '0) begin
            wait_q <= wait_q - 1'b1;
          end else if (st.last) begin
            state_q <= ST_IDLE;
          end else begin
            idx_q <= idx_q + 1'b1;
            state_q <= ST_ISSUE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // link pins
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      link.cmd <= CMD_NOP;
      link.mr_sel <= 3'h0;
      link.addr <= 14'h0000;
    end else if (state_q == ST_ISSUE) begin
      link.cmd <= st.cmd;
      link.mr_sel <= st.mr;
      link.addr <= st.addr;
    end else begin
      link.cmd <= CMD_NOP;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      link.cke <= 1'b1;
    end else if (state_q == ST_ISSUE) begin
      link.cke <= st.cke;
    end else if (state_q == ST_IDLE) begin
      link.cke <= 1'b1;
    end
  end

  // odt low while any sequence runs
  always_ff @(posedge mclk) begin
    if (reset) begin
      link.odt <= 1'b0;
    end else begin
      link.odt <= state_q == ST_IDLE && !go && cfg_q[CFG_ODT];
    end
  end

  // ----------------------------------------
  // ahb-lite slave, one wait state
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      ap_q <= 1'b0;
      apw_q <= 1'b0;
      apa_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (!ap_q && hsel && htrans == HTRANS_NONSEQ && hready) begin
      ap_q <= 1'b1;
      apw_q <= hwrite;
      apa_q <= haddr[7:0];
      hreadyout <= 1'b0;
    end else begin
      ap_q <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  always_comb begin
    wr_ctrl = 1'b0;
    wr_status = 1'b0;
    wr_cfg = 1'b0;
    if (ap_q && apw_q && apa_q == REG_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (ap_q && apw_q && apa_q == REG_STATUS) begin
      wr_status = 1'b1;
    end else if (ap_q && apw_q && apa_q == REG_CFG) begin
      wr_cfg = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_q && !apw_q && apa_q == REG_STATUS) begin
      hrdata <= {26'h0, idx_q, refused_q, done_q, state_q != ST_IDLE};
    end else if (ap_q && !apw_q && apa_q == REG_CFG) begin
      hrdata <= {20'h0, cfg_q};
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end

  // config frozen while a sequence runs
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_q <= CFG_RESET;
    end else if (wr_cfg && state_q == ST_IDLE) begin
      cfg_q <= hwdata[CFG_W-1:0];
    end
  end

  // set wins over the write-one clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      done_q <= seq_end | (done_q & ~(wr_status & hwdata[ST_DONE]));
      refused_q <= (go && state_q != ST_IDLE) |
                   (refused_q & ~(wr_status & hwdata[ST_REFUSED]));
    end
  end

endmodule

// file: verification/mode_link_props.sv
module mode_link_props
  import ddr_mode_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic cke,
  input wire logic odt,
  input wire cmd_t cmd,
  input wire logic [2:0] mr_sel,
  input wire logic [13:0] addr
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----
  // elapsed cycles since link events
  // ----
  // ages saturate so a long idle never wraps into a false early hit
  localparam int SR_MIN = T_CKSRE_CYC + T_CKSRX_CYC;
  logic [11:0] srx_q, sre_q, mrs_q, dll_q, zq_q;
  logic owed_q;
  logic mrs, vref_wr, dll_on;
  assign mrs = (cmd == CMD_MRS);
  assign vref_wr = mrs && (mr_sel == MR_VREF);
  assign dll_on = mrs && (mr_sel == MR1) && addr[MR1_DLL_EN];

  function automatic logic [11:0] age_f(input logic [11:0] v,
                                        input logic hit);
    if (hit) begin
      return 12'h001;
    end
    return (v == 12'hFFF) ? v : v + 12'h001;
  endfunction

  always_ff @(posedge mclk) begin
    if (reset) begin
      srx_q <= 12'hFFF;
      sre_q <= 12'hFFF;
      mrs_q <= 12'hFFF;
      dll_q <= 12'hFFF;
      zq_q <= 12'hFFF;
      owed_q <= 1'h0;
    end else begin
      srx_q <= age_f(srx_q, cmd == CMD_SRX);
      sre_q <= age_f(sre_q, cmd == CMD_SRE);
      mrs_q <= age_f(mrs_q, mrs);
      dll_q <= age_f(dll_q, mrs && mr_sel == MR0 && addr[MR0_DLL_RST]);
      zq_q <= age_f(zq_q, cmd == CMD_ZQCL);
      owed_q <= (cmd == CMD_SRX) || (owed_q && cmd != CMD_REF);
    end
  end

  // ----
  // link rules
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  a_train_enable:
    assert property (vref_wr |-> addr[VREF_TRAIN_BIT])
    else $error("vref slot written with training off");
  a_reserved_zero:
    assert property (vref_wr |-> !addr[13] && addr[9:8] == 2'h0
      && addr[12:10] <= CCD_MAX_CODE)
    else $error("reserved bits or code in vref slot write");
  a_exit_spacing:
    assert property (cmd == CMD_SRX |-> sre_q >= SR_MIN)
    else $error("self refresh left too early");
  a_mod_gap:
    assert property (cmd inside {CMD_SRE, CMD_REF, CMD_ZQCL}
      |-> mrs_q >= T_MOD_CYC)
    else $error("command too soon after mode write");
  a_cke_held:
    assert property (!cke |-> srx_q > T_MOD_CYC && dll_q > DLLK_LOW_CK)
    else $error("clock enable dropped inside exit window");
  a_odt_held:
    assert property (odt |-> srx_q > T_MOD_CYC && dll_q > DLLK_LOW_CK)
    else $error("termination raised inside exit window");
  a_fast_exit:
    assert property (cmd != CMD_NOP |-> srx_q >= T_XS_FAST_CYC)
    else $error("command before fast exit time");
  a_full_exit:
    assert property (cmd inside {CMD_ACT, CMD_PRE, CMD_PREA, CMD_REF,
      CMD_SRE, CMD_PDE, CMD_WR, CMD_RD} |-> srx_q >= T_XS_CYC)
    else $error("command before full exit time");
  a_dll_enable:
    assert property (dll_on |-> srx_q >= T_XS_ABORT_CYC)
    else $error("dll enabled before exit wait");
  a_mrd_gap:
    assert property (dll_on |=> (cmd != CMD_MRS) [*7])
    else $error("dll reset too soon after enable");
  a_lock_wait:
    assert property (cmd == CMD_REF
      |-> dll_q >= DLLK_LOW_CK && zq_q >= T_ZQOPER_CK)
    else $error("refresh before lock or calibration");
  a_refresh_owed:
    assert property (cmd == CMD_SRE |-> !owed_q)
    else $error("self refresh reentered without refresh");
  a_off_quiet:
    assert property (mrs && mr_sel == MR1 && !addr[MR1_DLL_EN] |-> !odt)
    else $error("dll turned off with termination active");
endmodule

// file: verification/testbench.sv
module testbench
  import ddr_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----
  // wiring
  // ----
  logic mclk, reset, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic dll_en_q, dll_locked_q, vref_range_q, vref_train_q, vref_bad_q;
  logic ccd_bad_q, self_ref_q, early_cmd_q;
  logic [13:0] vref_level_q;
  logic [3:0] ccd_l_q;
  logic [15:0] ref_count_q;
  int err_count, samples_checked, cycles;

  mode_link_if link_bus();
  mode_seq_ctrl mode_seq_ctrl_inst(.mclk, .reset, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .link(link_bus));
  dram_mode_end dram_mode_end_inst(.mclk, .reset, .link(link_bus), .dll_en_q,
    .dll_locked_q, .vref_level_q, .vref_range_q, .vref_train_q, .vref_bad_q,
    .ccd_l_q, .ccd_bad_q, .self_ref_q, .ref_count_q, .early_cmd_q);
  mode_link_props props_inst(.mclk, .reset, .cke(link_bus.cke),
    .odt(link_bus.odt), .cmd(link_bus.cmd), .mr_sel(link_bus.mr_sel),
    .addr(link_bus.addr));

  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  // run needs under 10000 cycles, so this only trips on a hang
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      final_report();
    end
  end

  // ----
  // shared tasks
  // ----
  task automatic final_report();
    $display("checked %0d mismatched %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask

  function automatic logic [31:0] cfg(input logic [5:0] code,
    input logic rng, input logic [2:0] ccd, input logic ab, input logic odt);
    return {20'h0, odt, ab, ccd, rng, code};
  endfunction

  task automatic start(input op_t op);
    wr(REG_CTRL, (32'(op) << CTRL_OP_LSB) | 32'h1);
  endtask

  // polls status, then clears done and refused together
  task automatic wait_done();
    logic [31:0] s;
    int n;
    s = 32'h0;
    n = 0;
    while (s[ST_DONE] !== 1'h1 && n < 4000) begin
      bus(1'h0, REG_STATUS, 32'h0, s);
      n++;
    end
    check(32'(s[ST_DONE]), 32'h1);
    wr(REG_STATUS, 32'h6);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    logic [31:0] q;
    check({dll_en_q, dll_locked_q, self_ref_q}, 32'h4);
    check(32'(vref_level_q), 32'h1770);
    check(32'(ccd_l_q), 32'h4);
    check({link_bus.cke, link_bus.odt, hresp}, 32'h4);
    bus(1'h0, REG_CFG, 32'h0, q);
    check(q, 32'(CFG_RESET));
    wr(8'h40, 32'hFFFFFFFF);
    bus(1'h0, 8'h40, 32'h0, q);
    check(q, 32'h0);
    $display("test reset finished");
  endtask

  task automatic t_vref();
    logic [5:0] code [5] = '{6'h00, 6'h01, 6'h13, 6'h32, 6'h0A};
    logic rng [5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
    logic [13:0] lvl [5] = '{14'h1770, 14'h17B1, 14'h1667, 14'h1E46,
                             14'h19FA};
    for (int i = 0; i < 5; i++) begin
      wr(REG_CFG, cfg(code[i], rng[i], 3'(i), 1'h0, 1'h0));
      start(OP_VREF);
      wait_done();
      check(32'(vref_level_q), 32'(lvl[i]));
      check({vref_range_q, vref_train_q, vref_bad_q}, {rng[i], 2'h2});
      check({ccd_bad_q, ccd_l_q}, 32'(i + 4));
    end
    // first code past the top level: flagged, level kept
    wr(REG_CFG, cfg(6'h33, 1'h0, 3'h0, 1'h0, 1'h0));
    start(OP_VREF);
    wait_done();
    check({vref_bad_q, vref_level_q}, {1'h1, 14'h19FA});
    $display("test vref finished");
  endtask

  task automatic t_refuse();
    logic [31:0] q;
    logic [15:0] refs;
    wr(REG_CFG, cfg(6'h05, 1'h0, 3'h1, 1'h0, 1'h1));
    refs = ref_count_q;
    start(OP_DLL_OFF);
    start(OP_DLL_ON);
    wr(REG_CFG, 32'h3F);
    bus(1'h0, REG_STATUS, 32'h0, q);
    check({q[2], q[0]}, 32'h3);
    bus(1'h0, REG_CFG, 32'h0, q);
    check(q, cfg(6'h05, 1'h0, 3'h1, 1'h0, 1'h1));
    wait_done();
    bus(1'h0, REG_STATUS, 32'h0, q);
    check(32'(q[2:1]), 32'h0);
    check({dll_en_q, self_ref_q, early_cmd_q}, 32'h0);
    check(32'(ref_count_q > refs), 32'h1);
    $display("test refuse finished");
  endtask

  task automatic t_cycle();
    logic [15:0] refs;
    for (int ab = 0; ab < 2; ab++) begin
      wr(REG_CFG, cfg(6'h05, 1'h0, 3'(2 + ab * 2), 1'(ab), 1'h1));
      start(OP_ABORT);
      wait_done();
      refs = ref_count_q;
      start(OP_DLL_ON);
      // entry lands two edges after go; exit is twenty-four edges later
      repeat (4) @(posedge mclk);
      check({self_ref_q, link_bus.cke}, 32'h2);
      wait_done();
      check({dll_en_q, dll_locked_q, early_cmd_q}, 32'h6);
      check(32'(ref_count_q > refs), 32'h1);
      start(OP_DLL_OFF);
      wait_done();
      check({dll_en_q, early_cmd_q}, 32'h0);
    end
    $display("test dll cycle finished");
  endtask

  initial begin
    reset = 1'h1;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    repeat (6) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    t_reset();
    t_vref();
    t_refuse();
    t_cycle();
    final_report();
  end
endmodule
